// ### logic/host_coprocessor_mailbox.sv
// host to local processor mailbox, memory map and interrupt control
`timescale 1ns/1ps
module host_coprocessor_mailbox
   import mailbox_pkg::*;
#(
   parameter int SWITCH_W = 7
)
(
   // clock and reset sources
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic bus_reset_n,
   input wire logic ext_reset_n,
   // host port base switch
   input wire logic [SWITCH_W-1:0] base_select_switch,
   // host port access
   input wire logic [7:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   output logic host_rdata_oe,
   // host interrupt
   output logic host_int_req,
   input wire logic host_int_ack,
   output logic [7:0] host_vector,
   output logic host_vector_oe,
   // local processor port access
   input wire logic [7:0] local_addr,
   input wire logic local_wr,
   input wire logic local_rd,
   input wire logic [7:0] local_wdata,
   output logic [7:0] local_rdata,
   // local interrupt
   output logic local_int_req,
   input wire logic local_int_ack,
   output logic [7:0] local_vector,
   // local memory map
   input wire logic [15:0] local_mem_addr,
   output logic rom_select,
   output logic ram_select,
   output logic map_all_ram,
   // local processor reset
   output logic local_cpu_reset_n
);
   logic board_reset_n;
   logic host_hit;
   logic host_wr_cmd, host_wr_data, host_rd_stat, host_rd_dout;
   logic loc_rd_cmd, loc_rd_din, loc_wr_stat, loc_wr_dout;
   logic loc_wr_ctrl, loc_wr_vec, loc_wr_memcfg;
   logic [7:0] cmd_byte, din_byte, stat_byte, dout_byte;
   logic cmd_full, din_full, stat_full, dout_full;
   logic [4:0] ctrl_reg;
   logic [7:0] hvec_reg;
   logic [HOLD_CNT_W-1:0] hold_cnt_reg;
   logic [LSRC_COUNT-1:0] lsrc;
   logic [7:0] flags;
   hint_state_type hint_reg, hint_next;

   // any of the three active-low reset sources resets the board
   board_reset_sync u_reset_sync
   (
      .clk_sys(clk_sys),
      .raw_reset_n(reset_n & bus_reset_n & ext_reset_n),
      .board_reset_n(board_reset_n)
   );

   // host decode against the switch base
   assign host_hit = host_addr[7:1] == base_select_switch;
   assign host_wr_cmd = host_hit && host_wr && host_addr[0] == HOST_OFS_CMD;
   assign host_wr_data = host_hit && host_wr && host_addr[0] == HOST_OFS_DATA;
   assign host_rd_stat = host_hit && host_rd && host_addr[0] == HOST_OFS_CMD;
   assign host_rd_dout = host_hit && host_rd && host_addr[0] == HOST_OFS_DATA;

   // local decode at fixed port numbers
   assign loc_rd_cmd = local_rd && local_addr == LPORT_CMD;
   assign loc_rd_din = local_rd && local_addr == LPORT_DATA;
   assign loc_wr_stat = local_wr && local_addr == LPORT_CMD;
   assign loc_wr_dout = local_wr && local_addr == LPORT_DATA;
   assign loc_wr_ctrl = local_wr && local_addr == LPORT_CTRL;
   assign loc_wr_vec = local_wr && local_addr == LPORT_VEC;
   assign loc_wr_memcfg = local_wr && local_addr[7:4] == LPORT_MEMCFG_HI;

   // the four mailbox bytes
   mailbox_slot #(.WIDTH(8)) u_cmd
   (
      .clk_sys(clk_sys), .reset_n(board_reset_n),
      .wr_en(host_wr_cmd), .wdata(host_wdata),
      .rd_en(loc_rd_cmd), .data_reg(cmd_byte), .full_reg(cmd_full)
   );
   mailbox_slot #(.WIDTH(8)) u_din
   (
      .clk_sys(clk_sys), .reset_n(board_reset_n),
      .wr_en(host_wr_data), .wdata(host_wdata),
      .rd_en(loc_rd_din), .data_reg(din_byte), .full_reg(din_full)
   );
   mailbox_slot #(.WIDTH(8)) u_stat
   (
      .clk_sys(clk_sys), .reset_n(board_reset_n),
      .wr_en(loc_wr_stat), .wdata(local_wdata),
      .rd_en(host_rd_stat), .data_reg(stat_byte), .full_reg(stat_full)
   );
   mailbox_slot #(.WIDTH(8)) u_dout
   (
      .clk_sys(clk_sys), .reset_n(board_reset_n),
      .wr_en(loc_wr_dout), .wdata(local_wdata),
      .rd_en(host_rd_dout), .data_reg(dout_byte), .full_reg(dout_full)
   );

   // flags byte for polling
   always_comb
   begin
      flags = BYTE_ZERO;
      flags[FLAG_CMD_FULL] = cmd_full;
      flags[FLAG_DIN_FULL] = din_full;
      flags[FLAG_STAT_FULL] = stat_full;
      flags[FLAG_DOUT_FULL] = dout_full;
      flags[FLAG_HINT_PEND] = hint_reg != HINT_IDLE;
      flags[FLAG_ALL_RAM] = map_all_ram;
   end

   // host read data, registered
   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
      begin
         host_rdata <= BYTE_ZERO;
         host_rdata_oe <= 1'b0;
      end
      else
      begin
         host_rdata_oe <= host_rd_stat || host_rd_dout;
         if (host_rd_stat)
            host_rdata <= stat_byte;
         else if (host_rd_dout)
            host_rdata <= dout_byte;
      end
   end

   // local read data, registered
   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
         local_rdata <= BYTE_ZERO;
      else if (local_rd)
      begin
         case (local_addr)
            LPORT_CMD: local_rdata <= cmd_byte;
            LPORT_DATA: local_rdata <= din_byte;
            LPORT_FLAGS: local_rdata <= flags;
            default: local_rdata <= UNMAPPED_READ;
         endcase
      end
   end

   // interrupt control register
   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
         ctrl_reg <= CTRL_RESET;
      else if (loc_wr_ctrl)
         ctrl_reg <= local_wdata[4:0];
   end

   // memory configuration, reset to ROM plus RAM
   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
         map_all_ram <= MEMCFG_RESET;
      else if (loc_wr_memcfg)
         map_all_ram <= local_wdata[MEMCFG_ALL_RAM_BIT];
   end

   // registered memory selects, one cycle after the address
   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
      begin
         rom_select <= 1'b0;
         ram_select <= 1'b0;
      end
      else
      begin
         rom_select <= !map_all_ram && local_mem_addr <= ROM_LAST;
         ram_select <= map_all_ram || (local_mem_addr > ROM_LAST
                       && local_mem_addr <= RAM_LAST);
      end
   end

   // local processor held in reset a few cycles past board reset
   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
      begin
         hold_cnt_reg <= '0;
         local_cpu_reset_n <= 1'b0;
      end
      else if (hold_cnt_reg != HOLD_CNT_W'(CPU_RESET_CYCLES))
         hold_cnt_reg <= hold_cnt_reg + 1'b1;
      else
         local_cpu_reset_n <= 1'b1;
   end

   // local interrupt sources: host wrote a byte or took one
   assign lsrc = {!dout_full, !stat_full, din_full, cmd_full} & ctrl_reg[3:0];

   // local interrupt request and vector
   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
      begin
         local_int_req <= 1'b0;
         local_vector <= LVEC_BASE;
      end
      else
      begin
         local_int_req <= |lsrc;
         if (local_int_ack)
         begin
            local_vector <= LVEC_BASE;
            for (int i = LSRC_COUNT - 1; i >= 0; i--)
               if (lsrc[i])
                  local_vector <= LVEC_BASE | 8'((i) << 1);
         end
      end
   end

   // host vector written by local software
   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
         hvec_reg <= BYTE_ZERO;
      else if (loc_wr_vec)
         hvec_reg <= local_wdata;
   end

   // host interrupt sequencer; a new vector write wins over the ack
   always_comb
   begin
      case (hint_reg)
         HINT_IDLE: hint_next = loc_wr_vec ? HINT_PEND : HINT_IDLE;
         HINT_PEND: hint_next = (host_int_ack && ctrl_reg[CTRL_HINT_EN]
                                 && !loc_wr_vec) ? HINT_VEC : HINT_PEND;
         HINT_VEC: hint_next = loc_wr_vec ? HINT_PEND : HINT_IDLE;
         default: hint_next = HINT_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
         hint_reg <= HINT_IDLE;
      else
         hint_reg <= hint_next;
   end

   // host interrupt outputs from flops
   always_ff @(posedge clk_sys or negedge board_reset_n)
   begin
      if (!board_reset_n)
      begin
         host_int_req <= 1'b0;
         host_vector <= BYTE_ZERO;
         host_vector_oe <= 1'b0;
      end
      else
      begin
         host_int_req <= hint_next == HINT_PEND && ctrl_reg[CTRL_HINT_EN];
         host_vector_oe <= hint_next == HINT_VEC;
         host_vector <= (hint_next == HINT_VEC) ? hvec_reg : BYTE_ZERO;
      end
   end

   // checks
   sequence s_host_cmd_write;
      host_wr_cmd && !loc_rd_cmd;
   endsequence
   sequence s_local_cmd_read;
      ##1 loc_rd_cmd;
   endsequence

   a_cmd_passes: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      s_host_cmd_write ##0 s_local_cmd_read |=> local_rdata == $past(host_wdata, 2))
      else $error("command byte not delivered");
   a_cmd_flag_seen: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      s_host_cmd_write ##1 !loc_rd_cmd ##1 (local_rd && local_addr == LPORT_FLAGS)
      |=> local_rdata[FLAG_CMD_FULL])
      else $error("command waiting flag missing");
   a_base_decode: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      host_wr && host_addr[7:1] != base_select_switch && !loc_rd_cmd
      |=> $stable(cmd_full))
      else $error("write off base changed mailbox");
   a_status_back: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      loc_wr_stat ##1 host_rd_stat |=> host_rdata_oe && host_rdata == $past(local_wdata, 2))
      else $error("status byte not delivered");
   a_map_switch: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      loc_wr_memcfg |=> map_all_ram == $past(local_wdata[MEMCFG_ALL_RAM_BIT]))
      else $error("memory map not switched");
   a_map_at_start: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      $rose(local_cpu_reset_n) |-> !map_all_ram)
      else $error("map not rom plus ram after reset");
   a_rom_window: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      !map_all_ram && !loc_wr_memcfg && local_mem_addr == ROM_LAST
      |=> rom_select && !ram_select)
      else $error("rom window wrong");
   a_cpu_hold: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      local_cpu_reset_n |-> hold_cnt_reg == HOLD_CNT_W'(CPU_RESET_CYCLES))
      else $error("local cpu released early");
   a_host_irq: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      loc_wr_vec && ctrl_reg[CTRL_HINT_EN] && !loc_wr_ctrl |=> host_int_req)
      else $error("host interrupt not raised");
   a_host_vector: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      host_vector_oe |-> host_vector == hvec_reg && !host_int_req)
      else $error("host vector wrong");
   a_local_irq: assert property (@(posedge clk_sys) disable iff (!board_reset_n)
      host_wr_cmd && ctrl_reg[0] && !loc_wr_ctrl && !loc_rd_cmd
      ##1 !loc_rd_cmd |=> local_int_req)
      else $error("local interrupt not raised");
endmodule : host_coprocessor_mailbox

// ### logic/mailbox_pkg.sv
// constants and types shared by the mailbox design files
package mailbox_pkg;
   // local processor port numbers, fixed
   localparam logic [7:0] LPORT_CMD = 8'h00;
   localparam logic [7:0] LPORT_DATA = 8'h01;
   localparam logic [7:0] LPORT_FLAGS = 8'h02;
   localparam logic [7:0] LPORT_CTRL = 8'h02;
   localparam logic [7:0] LPORT_VEC = 8'h03;
   localparam logic [3:0] LPORT_MEMCFG_HI = 4'h4;
   // host port offsets from the switch base
   localparam logic HOST_OFS_CMD = 1'b0;
   localparam logic HOST_OFS_DATA = 1'b1;
   // memory map limits
   localparam logic [15:0] ROM_LAST = 16'h3fff;
   localparam logic [15:0] RAM_LAST = 16'hbfff;
   // memory configuration bit and its reset value
   localparam int MEMCFG_ALL_RAM_BIT = 0;
   localparam logic MEMCFG_RESET = 1'b0;
   // flag port bit positions
   localparam int FLAG_CMD_FULL = 0;
   localparam int FLAG_DIN_FULL = 1;
   localparam int FLAG_STAT_FULL = 2;
   localparam int FLAG_DOUT_FULL = 3;
   localparam int FLAG_HINT_PEND = 4;
   localparam int FLAG_ALL_RAM = 5;
   // control port: bits 3..0 enable local sources, bit 4 enables host interrupt
   localparam int CTRL_HINT_EN = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam int LSRC_COUNT = 4;
   // local interrupt vector base; low bits carry the source number
   localparam logic [7:0] LVEC_BASE = 8'he0;
   localparam logic [7:0] UNMAPPED_READ = 8'hff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // local processor reset stretch after board reset release
   localparam int CLK_PERIOD_NS = 25;
   localparam int CPU_RESET_HOLD_NS = 100;
   localparam int CPU_RESET_CYCLES = (CPU_RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CNT_W = 4;
   // host interrupt sequencer states
   typedef enum logic [2:0] {
      HINT_IDLE = 3'b001,
      HINT_PEND = 3'b010,
      HINT_VEC = 3'b100
   } hint_state_type;
endpackage : mailbox_pkg

// ### logic/board_reset_sync.sv
// board reset synchroniser: async assert, clocked release
`timescale 1ns/1ps
module board_reset_sync
(
   // clock and raw active-low reset
   input wire logic clk_sys,
   input wire logic raw_reset_n,
   // synchronised board reset
   output logic board_reset_n
);
   logic meta_reg;

   // two flops; the first is read only by the second
   always_ff @(posedge clk_sys or negedge raw_reset_n)
   begin
      if (!raw_reset_n)
      begin
         meta_reg <= 1'b0;
         board_reset_n <= 1'b0;
      end
      else
      begin
         meta_reg <= 1'b1;
         board_reset_n <= meta_reg;
      end
   end
endmodule : board_reset_sync

// ### logic/mailbox_slot.sv
// one mailbox byte with its full flag
`timescale 1ns/1ps
module mailbox_slot
#(
   parameter int WIDTH = 8
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // writer side
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wdata,
   // reader side
   input wire logic rd_en,
   output logic [WIDTH-1:0] data_reg,
   output logic full_reg
);
   // byte store
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         data_reg <= '0;
      else if (wr_en)
         data_reg <= wdata;
   end

   // full flag, a write in the same cycle as the read wins
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         full_reg <= 1'b0;
      else if (wr_en)
         full_reg <= 1'b1;
      else if (rd_en)
         full_reg <= 1'b0;
   end

   a_slot_set_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_en |=> full_reg && data_reg == $past(wdata))
      else $error("slot write not stored");
   a_slot_read_empties: assert property (@(posedge clk_sys) disable iff (!reset_n)
      rd_en && !wr_en |=> !full_reg)
      else $error("slot read left flag set");
endmodule : mailbox_slot

// ### tb/host_bus_model.sv
// host processor model driving the host side of the mailbox
`timescale 1ns/1ps
module host_bus_model
(
   // clock
   input wire logic clk_sys,
   // host port strobes and data
   output logic [7:0] host_addr,
   output logic host_wr,
   output logic host_rd,
   output logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   input wire logic host_rdata_oe,
   // host interrupt
   input wire logic host_int_req,
   output logic host_int_ack,
   input wire logic [7:0] host_vector,
   input wire logic host_vector_oe
);
   // idle bus at time zero
   initial
   begin
      host_addr = 8'h00;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 8'h00;
      host_int_ack = 1'b0;
   end

   // one write cycle; released lines show the inverse of the last value
   task automatic host_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      host_addr <= addr;
      host_wdata <= data;
      host_wr <= 1'b1;
      @(posedge clk_sys);
      host_wr <= 1'b0;
      host_addr <= ~addr;
      host_wdata <= ~data;
   endtask : host_write

   // one read cycle, noting whether the board drove the data bus
   task automatic host_read(input logic [7:0] addr, output logic [7:0] data, output logic oe);
      @(posedge clk_sys);
      host_addr <= addr;
      host_rd <= 1'b1;
      @(posedge clk_sys);
      host_rd <= 1'b0;
      host_addr <= ~addr;
      oe = 1'b0;
      repeat (2)
      begin
         #1;
         if (host_rdata_oe === 1'b1)
            oe = 1'b1;
         @(posedge clk_sys);
      end
      #1;
      data = host_rdata;
   endtask : host_read

   // interrupt acknowledge after a chosen delay, capturing the vector
   task automatic host_ack(input int dly, output logic [7:0] vec, output logic ok);
      vec = 8'h00;
      ok = 1'b0;
      repeat (dly) @(posedge clk_sys);
      @(posedge clk_sys);
      host_int_ack <= 1'b1;
      @(posedge clk_sys);
      host_int_ack <= 1'b0;
      repeat (2)
      begin
         #1;
         if (host_vector_oe === 1'b1)
         begin
            ok = 1'b1;
            vec = host_vector;
         end
         @(posedge clk_sys);
      end
   endtask : host_ack
endmodule : host_bus_model

// ### tb/tb.sv
// self-checking bench for the host coprocessor mailbox
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] BASE = 8'hce;
   logic clk_sys, reset_n, bus_reset_n, ext_reset_n;
   logic [6:0] base_select_switch;
   logic [7:0] host_addr, host_wdata, host_rdata, host_vector;
   logic host_wr, host_rd, host_rdata_oe, host_int_req, host_int_ack, host_vector_oe;
   logic [7:0] local_addr, local_wdata, local_rdata, local_vector;
   logic local_wr, local_rd, local_int_req, local_int_ack;
   logic [15:0] local_mem_addr;
   logic rom_select, ram_select, map_all_ram, local_cpu_reset_n;
   int error_cnt = 0;
   int check_count = 0;
   logic [7:0] d;
   logic ok;

   // device under test
   host_coprocessor_mailbox #(.SWITCH_W(7)) u_host_coprocessor_mailbox (.clk_sys, .reset_n,
      .bus_reset_n, .ext_reset_n, .base_select_switch, .host_addr, .host_wr, .host_rd,
      .host_wdata, .host_rdata, .host_rdata_oe, .host_int_req, .host_int_ack, .host_vector,
      .host_vector_oe, .local_addr, .local_wr, .local_rd, .local_wdata, .local_rdata,
      .local_int_req, .local_int_ack, .local_vector, .local_mem_addr, .rom_select,
      .ram_select, .map_all_ram, .local_cpu_reset_n);

   // host processor on the far side
   host_bus_model u_host_bus_model (.clk_sys, .host_addr, .host_wr, .host_rd, .host_wdata,
      .host_rdata, .host_rdata_oe, .host_int_req, .host_int_ack, .host_vector,
      .host_vector_oe);

   // 40 MHz clock
   always #12.5 clk_sys = ~clk_sys;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk

   task automatic summarize;
      if (error_cnt == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   // local port write and read, one strobe cycle each
   task automatic lw(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      local_addr <= a;
      local_wdata <= v;
      local_wr <= 1'b1;
      @(posedge clk_sys);
      local_wr <= 1'b0;
   endtask : lw

   task automatic lr(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      local_addr <= a;
      local_rd <= 1'b1;
      @(posedge clk_sys);
      local_rd <= 1'b0;
      @(posedge clk_sys);
      #1;
      v = local_rdata;
   endtask : lr

   // bounded wait for a level to rise
   task automatic wait_hi(input int sel);
      int n;
      for (n = 0; n < 8 && (sel != 0 ? local_int_req : host_int_req) !== 1'b1; n++)
      begin
         @(posedge clk_sys);
         #1;
      end
   endtask : wait_hi

   // memory selects for one address
   task automatic mchk(input logic [15:0] a, input logic rom, input logic ram);
      @(posedge clk_sys);
      local_mem_addr <= a;
      repeat (2) @(posedge clk_sys);
      #1;
      chk({rom_select, ram_select}, {rom, ram});
   endtask : mchk

   // reset from one source, release timing and the reset memory map
   task automatic t_reset(input int src, input int hold);
      int n;
      @(posedge clk_sys);
      reset_n <= (src != 0);
      bus_reset_n <= (src != 1);
      ext_reset_n <= (src != 2);
      repeat (hold) @(posedge clk_sys);
      #1;
      chk({local_cpu_reset_n, map_all_ram, host_int_req}, 3'b000);
      chk(local_vector, 8'he0);
      @(posedge clk_sys);
      reset_n <= 1'b1;
      bus_reset_n <= 1'b1;
      ext_reset_n <= 1'b1;
      for (n = 0; n < 12 && local_cpu_reset_n !== 1'b1; n++)
      begin
         @(posedge clk_sys);
         #1;
      end
      chk(n >= 5 && n <= 10, 1'b1);
      mchk(16'h0000, 1'b1, 1'b0);
      mchk(16'h3fff, 1'b1, 1'b0);
      mchk(16'h4000, 1'b0, 1'b1);
      mchk(16'hbfff, 1'b0, 1'b1);
      mchk(16'hc000, 1'b0, 1'b0);
   endtask : t_reset

   // host command and data bytes reach the local side; base decoding
   task automatic t_cmd;
      u_host_bus_model.host_write(BASE, 8'h5a);
      lr(8'h02, d);
      chk(d & 8'h01, 8'h01);
      lr(8'h00, d);
      chk(d, 8'h5a);
      lr(8'h02, d);
      chk(d & 8'h01, 8'h00);
      u_host_bus_model.host_write(BASE + 8'h01, 8'ha5);
      lr(8'h01, d);
      chk(d, 8'ha5);
      u_host_bus_model.host_write(8'hd0, 8'h3c);
      lr(8'h02, d);
      chk(d & 8'h03, 8'h00);
      @(posedge clk_sys);
      base_select_switch <= 7'h68;
      u_host_bus_model.host_write(8'hd0, 8'h3c);
      lr(8'h00, d);
      chk(d, 8'h3c);
      @(posedge clk_sys);
      base_select_switch <= 7'h67;
      // local read of the command in the cycle right after the host write
      fork
         u_host_bus_model.host_write(BASE, 8'h96);
         begin
            @(posedge clk_sys);
            lr(8'h00, d);
         end
      join
      chk(d, 8'h96);
   endtask : t_cmd

   // local status and data reach the host
   task automatic t_stat;
      lw(8'h00, 8'h81);
      lw(8'h01, 8'h7e);
      lr(8'h02, d);
      chk(d & 8'h0c, 8'h0c);
      u_host_bus_model.host_read(BASE, d, ok);
      chk({ok, d}, 9'h181);
      u_host_bus_model.host_read(BASE + 8'h01, d, ok);
      chk({ok, d}, 9'h17e);
      u_host_bus_model.host_read(8'hd2, d, ok);
      chk(ok, 1'b0);
      lr(8'h02, d);
      chk(d & 8'h0c, 8'h00);
      lr(8'h07, d);
      chk(d, 8'hff);
      // host reads the status in the cycle right after the local write
      fork
         lw(8'h00, 8'h3d);
         begin
            @(posedge clk_sys);
            u_host_bus_model.host_read(BASE, d, ok);
         end
      join
      chk({ok, d}, 9'h13d);
   endtask : t_stat

   // vectored host interrupt, masked then enabled
   task automatic t_hint(input int dly, input logic [7:0] v);
      lw(8'h02, 8'h00);
      lw(8'h03, v);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(host_int_req, 1'b0);
      lr(8'h02, d);
      chk(d & 8'h10, 8'h10);
      lw(8'h02, 8'h10);
      wait_hi(0);
      chk(host_int_req, 1'b1);
      u_host_bus_model.host_ack(dly, d, ok);
      chk({ok, d}, {1'b1, v});
      #1;
      chk(host_int_req, 1'b0);
      // a vector written while enabled raises the request at once
      lw(8'h03, ~v);
      wait_hi(0);
      chk(host_int_req, 1'b1);
      u_host_bus_model.host_ack(0, d, ok);
      chk({ok, d}, {1'b1, ~v});
      #1;
      chk(host_int_req, 1'b0);
   endtask : t_hint

   // local interrupt from one source with its vector
   task automatic t_lint(input int s);
      lw(8'h02, 8'h01 << s);
      if (s < 2)
         u_host_bus_model.host_write(BASE + s[7:0], 8'h11);
      wait_hi(1);
      chk(local_int_req, 1'b1);
      @(posedge clk_sys);
      local_int_ack <= 1'b1;
      @(posedge clk_sys);
      local_int_ack <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(local_vector, 8'he0 | (s[7:0] << 1));
      if (s < 2)
         lr(s[7:0], d);
      else
         lw(s[7:0] - 8'h02, 8'h00);
      lw(8'h02, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(local_int_req, 1'b0);
   endtask : t_lint

   // memory map switch through the configuration port
   task automatic t_mem;
      lw(8'h47, 8'h01);
      lr(8'h02, d);
      chk(d & 8'h20, 8'h20);
      chk(map_all_ram, 1'b1);
      mchk(16'h0000, 1'b0, 1'b1);
      mchk(16'hffff, 1'b0, 1'b1);
      lw(8'h40, 8'h00);
      mchk(16'h0000, 1'b1, 1'b0);
      lw(8'h4c, 8'h01);
   endtask : t_mem

   // main sequence
   initial
   begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      bus_reset_n = 1'b0;
      ext_reset_n = 1'b0;
      base_select_switch = 7'h67;
      local_addr = 8'h00;
      local_wr = 1'b0;
      local_rd = 1'b0;
      local_wdata = 8'h00;
      local_int_ack = 1'b0;
      local_mem_addr = 16'h0000;
      t_reset(0, 3);
      t_cmd();
      t_stat();
      t_hint(0, 8'h9c);
      t_hint(3, 8'h44);
      for (int s = 0; s < 4; s++)
         t_lint(s);
      t_mem();
      t_reset(1, 8);
      t_reset(2, 3);
      summarize();
   end

   // cut a hang short
   initial
   begin
      #(25 * 4000);
      error_cnt++;
      summarize();
   end
endmodule : tb
